// *** rtl/ext_bus_pkg.sv ***
package ext_bus_pkg;

   // core output clock is mclk divided by four; phase counter walks 0..3
   localparam int MCLK_PERIOD_NS = 10;
   localparam int CORE_CLK_PERIOD_NS = 40;
   localparam int CORE_CLK_DIV = CORE_CLK_PERIOD_NS / MCLK_PERIOD_NS;
   localparam logic [1:0] PHASE_RESET = 2'h0;
   localparam logic [1:0] PHASE_LAST = 2'(CORE_CLK_DIV - 1);
   // core clock rises when the phase leaves this value; pin changes happen here
   localparam logic [1:0] PHASE_PRE_RISE = 2'h1;

   // pin levels after reset
   localparam logic LOCK_N_RESET = 1'b1;
   localparam logic REQ_N_RESET = 1'b1;
   localparam logic LOCK_RESET = 1'b0;

   typedef enum logic [1:0]
   {
      OP_OTHER,
      OP_BIT_SET_INSTR,
      OP_BIT_CLEAR_INSTR,
      OP_BIT_CHANGE_INSTR
   } instr_op_t;

   // requests from the core sequencer, sampled on core clock edges only
   typedef struct packed
   {
      logic need_bus;
      logic cycle_start;
      logic cycle_end;
      logic rmw_read;
      logic rmw_write;
      logic ext_target;
      logic cas_n;
      instr_op_t op;
   } core_req_t;

   // control bits that live in the bus, dram and mode control registers
   typedef struct packed
   {
      logic lock_hold_bit;
      logic mastership_enable_bit;
      logic address_tracing_enable;
   } bus_cfg_t;

   typedef struct packed
   {
      logic is_master;
      logic cycle_grant;
      logic cycle_taken;
      logic locked;
   } core_status_t;

   // one driven pin: level and enable
   typedef struct packed
   {
      logic o;
      logic oe;
   } pin_drive_t;

endpackage

// *** rtl/ext_bus_mastership_lock.sv ***
`timescale 1ns/1ps
`default_nettype none

module ext_bus_mastership_lock
(
   input wire logic mclk,
   input wire logic nrst,
   input wire ext_bus_pkg::core_req_t core_req,
   input wire ext_bus_pkg::bus_cfg_t bus_cfg,
   output ext_bus_pkg::core_status_t core_status,
   output logic core_clock_out,
   input wire logic bus_grant_n,
   input wire logic bus_busy_n_in,
   output ext_bus_pkg::pin_drive_t bus_busy_n,
   output logic bus_request_n,
   output logic bus_lock_n,
   output ext_bus_pkg::pin_drive_t cas_n,
   output ext_bus_pkg::pin_drive_t bus_clk,
   output ext_bus_pkg::pin_drive_t bus_clk_inv
);

   typedef enum logic [1:0]
   {
      ST_SLAVE,
      ST_WAIT,
      ST_OWN,
      ST_RELEASE
   } arb_state_t;

   arb_state_t state_reg;
   arb_state_t state_next;
   logic [1:0] phase_reg;
   logic [1:0] phase_next;
   logic req_n_reg;
   logic lock_reg;
   logic lock_next;
   logic hold_reg;
   logic cycle_active_reg;
   logic cycle_active_next;
   logic cas_n_reg;

   wire logic tick;
   wire logic granted;
   wire logic bb_free;
   wire logic owning;
   wire logic is_master;
   wire logic cycle_grant;
   wire logic start_taken;
   wire logic end_taken;
   wire logic lock_trigger;
   wire logic lock_end;
   wire logic may_release;
   wire logic bclk_active;
   wire logic bclk_wave;

   // phase counter makes the core clock and the edge tick
   assign phase_next = (phase_reg == ext_bus_pkg::PHASE_LAST) ? ext_bus_pkg::PHASE_RESET : phase_reg + 2'h1;
   assign tick = (phase_reg == ext_bus_pkg::PHASE_PRE_RISE);
   assign core_clock_out = phase_reg[1];

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         phase_reg <= ext_bus_pkg::PHASE_RESET;
      else
         phase_reg <= phase_next;
   end

   // pin decode; grant and busy are taken as synchronous to the core clock
   assign granted = !bus_grant_n;
   assign bb_free = bus_busy_n_in;
   assign owning = (state_reg == ST_OWN);
   assign is_master = owning || (state_reg == ST_RELEASE);

   // a locked sequence keeps its cycles even after grant is withdrawn
   assign cycle_grant = owning && (granted || lock_reg);
   assign start_taken = tick && core_req.cycle_start && cycle_grant && !cycle_active_reg;
   assign end_taken = tick && core_req.cycle_end && cycle_active_reg;
   assign may_release = !granted && !cycle_active_reg && !lock_reg && !core_req.cycle_start;

   // arbitration: parking keeps ownership while grant stays, whatever the request
   always_comb
   begin
      state_next = state_reg;
      if (tick)
      begin
         unique case (state_reg)
            ST_SLAVE:
               if (granted && core_req.need_bus)
                  state_next = bb_free ? ST_OWN : ST_WAIT;
            ST_WAIT:
               if (!granted)
                  state_next = ST_SLAVE;
               else if (bb_free)
                  state_next = ST_OWN;
            ST_OWN:
               if (may_release)
                  state_next = ST_RELEASE;
            ST_RELEASE:
               state_next = ST_SLAVE;
         endcase
      end
   end

   // bus cycle tracking, one cycle outstanding at a time
   always_comb
   begin
      cycle_active_next = cycle_active_reg;
      if (start_taken)
         cycle_active_next = 1'b1;
      else if (end_taken)
         cycle_active_next = 1'b0;
   end

   // lock on the read start of an external bit set, clear or change
   assign lock_trigger = start_taken && core_req.rmw_read && core_req.ext_target
                         && (core_req.op != ext_bus_pkg::OP_OTHER);
   assign lock_end = end_taken && core_req.rmw_write;

   always_comb
   begin
      lock_next = lock_reg;
      if (lock_trigger)
         lock_next = 1'b1;
      else if (lock_end)
         lock_next = 1'b0;
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_reg <= ST_SLAVE;
         cycle_active_reg <= 1'b0;
         lock_reg <= ext_bus_pkg::LOCK_RESET;
      end
      else
      begin
         state_reg <= state_next;
         cycle_active_reg <= cycle_active_next;
         lock_reg <= lock_next;
      end
   end

   // request and software lock-hold follow the core clock edge
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         req_n_reg <= ext_bus_pkg::REQ_N_RESET;
         hold_reg <= ext_bus_pkg::LOCK_RESET;
         cas_n_reg <= 1'b1;
      end
      else if (tick)
      begin
         req_n_reg <= !core_req.need_bus;
         hold_reg <= bus_cfg.lock_hold_bit;
         cas_n_reg <= core_req.cas_n;
      end
   end

   assign bus_request_n = req_n_reg;
   // reset clears both sources, so the pin is driven high in reset
   assign bus_lock_n = !(lock_reg || hold_reg);

   // active pull-up: driven low while owning, high for one core clock, then released
   // whole-struct drives keep a single continuous driver per output
   assign bus_busy_n = {(state_reg == ST_RELEASE),
                        is_master};

   // column strobe: follows the core as master, parked high when enabled as slave
   assign cas_n = {(is_master ? cas_n_reg : 1'b1),
                   (is_master || bus_cfg.mastership_enable_bit)};

   // bus clock high in phases 1..2, core clock in 2..3: a quarter period ahead
   assign bclk_active = is_master && bus_cfg.address_tracing_enable;
   assign bclk_wave = phase_reg[1] ^ phase_reg[0];
   assign bus_clk = {(bclk_active && bclk_wave),
                     is_master};
   assign bus_clk_inv = {!bus_clk.o,
                         is_master};

   // status back to the core sequencer
   assign core_status = {is_master, cycle_grant, start_taken, !bus_lock_n};

   // ---------------- assertions ----------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   sequence s_release_high;
      bus_busy_n.oe && bus_busy_n.o;
   endsequence

   sequence s_released;
      !bus_busy_n.oe;
   endsequence

   AST_BB_ON_EDGE: assert property (($changed(bus_busy_n.oe) || $changed(bus_busy_n.o))
                                    |-> $past(tick))
      else $error("bus busy changed away from a core clock edge");

   AST_NO_TAKE_WHILE_BUSY: assert property ($rose(owning) && $past(state_reg) != ST_RELEASE
                                            |-> $past(bb_free))
      else $error("took the bus while bus busy was asserted");

   AST_PARK_HOLDS: assert property (tick && owning && granted && !core_req.need_bus
                                    |=> owning && bus_busy_n.oe && !bus_busy_n.o)
      else $error("parked owner dropped the bus while granted");

   AST_PARK_REUSE: assert property (owning && granted |-> cycle_grant)
      else $error("parked owner refused a new transfer");

   AST_ACTIVE_PULLUP: assert property ($rose(state_reg == ST_RELEASE)
                                       |-> s_release_high [*4] ##1 s_released)
      else $error("bus busy release was not high then undriven");

   AST_LOCK_AT_START: assert property (lock_trigger |=> !bus_lock_n)
      else $error("bus lock missing at read-modify-write start");

   AST_LOCK_BETWEEN: assert property (lock_reg && !lock_end |=> lock_reg)
      else $error("bus lock dropped inside the sequence");

   AST_LOCK_END: assert property (lock_end && !lock_trigger && !bus_cfg.lock_hold_bit |=> bus_lock_n)
      else $error("bus lock not released at end of write");

   AST_LOCK_CAUSE: assert property ($fell(bus_lock_n) |-> $past(lock_trigger) || hold_reg)
      else $error("bus lock asserted without a cause");

   AST_CAS_TRISTATE: assert property (!is_master && !bus_cfg.mastership_enable_bit
                                      |-> !cas_n.oe)
      else $error("column strobe driven while not master");

   AST_BCLK_QUIET: assert property (!bclk_active |-> !bus_clk.o)
      else $error("bus clock toggled while inactive");

   AST_BCLK_LEAD: assert property (bclk_active && phase_reg == ext_bus_pkg::PHASE_PRE_RISE
                                   |-> bus_clk.o && !core_clock_out ##1 core_clock_out)
      else $error("bus clock does not lead the core clock");

   AST_BCLK_INV: assert property (is_master |-> bus_clk_inv.oe && (bus_clk_inv.o != bus_clk.o))
      else $error("complementary bus clock is not the inverse");

   AST_BCLK_INV_Z: assert property (!is_master |-> !bus_clk_inv.oe)
      else $error("complementary bus clock driven while not master");

   AST_REQ_FOLLOWS: assert property (tick |=> bus_request_n == !$past(core_req.need_bus))
      else $error("bus request does not follow need");

   AST_GIVE_UP: assert property (tick && owning && may_release |=> state_reg == ST_RELEASE)
      else $error("mastership kept after grant withdrawn");

   AST_WAIT_NO_DRIVE: assert property (state_reg == ST_WAIT |-> !bus_busy_n.oe)
      else $error("waiting master drove bus busy");

   AST_RELEASE_IDLE: assert property ($rose(state_reg == ST_RELEASE)
                                      |-> $past(bus_grant_n) && !$past(cycle_active_reg) && !$past(lock_reg))
      else $error("bus released while granted, busy or locked");

   AST_LOCK_HOLD: assert property (tick && bus_cfg.lock_hold_bit |=> !bus_lock_n)
      else $error("lock-hold bit did not assert bus lock");

   AST_CAS_DRIVE: assert property (is_master |-> cas_n.oe && (cas_n.o == cas_n_reg))
      else $error("column strobe not driven from the core as master");

   AST_BCLK_OE: assert property (!is_master |-> !bus_clk.oe)
      else $error("bus clock driven while not master");

   // pins that follow the core request may only move on a core clock edge
   AST_REQ_ON_EDGE: assert property (!$past(tick) |-> $stable(bus_request_n) && $stable(bus_lock_n))
      else $error("bus request or lock moved away from a core clock edge");

   // checked while reset is held, so the default disable is overridden
   AST_RESET_PINS: assert property (disable iff (1'b0) !nrst
                                    |-> !bus_busy_n.oe && bus_lock_n && bus_request_n)
      else $error("pins not at their reset levels during reset");

endmodule // ext_bus_mastership_lock

`default_nettype wire

// *** tb/bus_arbiter_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module bus_arbiter_model
(
   input wire logic core_clock_out,
   input wire logic nrst,
   input wire logic grant_on,
   input wire logic other_busy,
   input wire ext_bus_pkg::pin_drive_t bus_busy_n,
   output logic bus_grant_n,
   output logic bus_busy_n_in
);
   logic grant_n_reg;
   logic other_drv_reg;

   // grant and the other master change only on core clock edges
   always_ff @(posedge core_clock_out or negedge nrst)
   begin
      if (!nrst)
      begin
         grant_n_reg <= 1'b1;
         other_drv_reg <= 1'b0;
      end
      else
      begin
         grant_n_reg <= !grant_on;
         other_drv_reg <= other_busy && !bus_busy_n.oe; // waits for a free line
      end
   end

   // resolved line: pull-up wins when nobody drives
   assign bus_grant_n = grant_n_reg;
   assign bus_busy_n_in = bus_busy_n.oe ? bus_busy_n.o : !other_drv_reg;
endmodule // bus_arbiter_model

`default_nettype wire

// *** tb/ext_bus_mastership_lock_bench.sv ***
`timescale 1ns/1ps
`default_nettype none

module ext_bus_mastership_lock_bench;
   logic mclk = 1'b0;
   logic nrst = 1'b1;
   logic grant_on = 1'b0;
   logic other_busy = 1'b0;
   ext_bus_pkg::core_req_t req = '0;
   ext_bus_pkg::bus_cfg_t cfg = '0;
   ext_bus_pkg::core_status_t st;
   ext_bus_pkg::pin_drive_t busy, cas, bclk, bclkn;
   logic ccl, grant_n, busy_in, req_n, lock_n;
   int mismatches = 0;
   int n_checks = 0;

   ext_bus_mastership_lock uut (.mclk(mclk), .nrst(nrst), .core_req(req), .bus_cfg(cfg),
      .core_status(st), .core_clock_out(ccl), .bus_grant_n(grant_n), .bus_busy_n_in(busy_in),
      .bus_busy_n(busy), .bus_request_n(req_n), .bus_lock_n(lock_n), .cas_n(cas),
      .bus_clk(bclk), .bus_clk_inv(bclkn));
   bus_arbiter_model arb (.core_clock_out(ccl), .nrst(nrst), .grant_on(grant_on),
      .other_busy(other_busy), .bus_busy_n(busy), .bus_grant_n(grant_n), .bus_busy_n_in(busy_in));

   // 100 MHz system clock
   initial
   begin
      forever #5 mclk = ~mclk;
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [1:0] exp, input logic [1:0] got);
      n_checks++;
      if (got !== exp)
      begin
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
         mismatches++;
      end
   endtask

   // lands in phase 0, well clear of the next tick edge
   task automatic tk(input int n);
      repeat (n)
      begin
         @(posedge ccl);
         repeat (2) @(posedge mclk);
         #1;
      end
   endtask

   task automatic s_acquire();
      other_busy = 1'b1;
      grant_on = 1'b1;
      req.need_bus = 1'b1;
      tk(3);
      chk("master_wait", 2'h0, {1'b0, st.is_master});
      chk("busy_wait", 2'h0, {1'b0, busy.oe});
      chk("req_n", 2'h0, {1'b0, req_n});
      other_busy = 1'b0;
      tk(3);
      chk("master", 2'h1, {1'b0, st.is_master});
      chk("busy_own", 2'h1, busy);
   endtask

   // read then write of one sequence; lock expected only for external bit ops
   // request fields in order: need, start, end, read, write, external, strobe, op
   task automatic s_rmw(input ext_bus_pkg::instr_op_t op, input logic ext);
      logic exp_n;
      exp_n = !(ext && op != ext_bus_pkg::OP_OTHER);
      req = {1'b1, 1'b1, 1'b0, 1'b1, 1'b0, ext, 1'b1, op};
      // start is accepted in the tick cycle itself, one mclk later
      @(posedge mclk);
      #1;
      chk("taken", 2'h1, {1'b0, st.cycle_taken});
      tk(1);
      chk("lock_read", {1'b0, exp_n}, {1'b0, lock_n});
      chk("locked", {1'b0, !exp_n}, {1'b0, st.locked});
      req.cycle_start = 1'b0;
      req.cycle_end = 1'b1;
      tk(1);
      req.cycle_end = 1'b0;
      req.rmw_read = 1'b0;
      chk("lock_between", {1'b0, exp_n}, {1'b0, lock_n});
      req.cycle_start = 1'b1;
      req.rmw_write = 1'b1;
      tk(1);
      chk("lock_write", {1'b0, exp_n}, {1'b0, lock_n});
      req.cycle_start = 1'b0;
      req.cycle_end = 1'b1;
      tk(1);
      chk("lock_end", 2'h1, {1'b0, lock_n});
      req = {7'h41, ext_bus_pkg::OP_OTHER};
      tk(2);
      chk("lock_idle", 2'h1, {1'b0, lock_n});
   endtask

   task automatic s_hold_park();
      cfg.lock_hold_bit = 1'b1;
      tk(2);
      chk("lock_hold", 2'h0, {1'b0, lock_n});
      cfg.lock_hold_bit = 1'b0;
      req.need_bus = 1'b0;
      tk(2);
      chk("lock_hold_off", 2'h1, {1'b0, lock_n});
      chk("park_busy", 2'h1, busy);
      chk("park_master", 2'h1, {1'b0, st.is_master});
      chk("park_req_n", 2'h1, {1'b0, req_n});
      chk("park_grant", 2'h1, {1'b0, st.cycle_grant});
      req.cas_n = 1'b0;
      tk(2);
      chk("cas_drive", 2'h1, cas);
      req.cas_n = 1'b1;
   endtask

   // bus clock toggling, inverse and its lead over the core clock
   task automatic s_clk();
      int edges;
      logic prev;
      edges = 0;
      cfg.address_tracing_enable = 1'b1;
      tk(2);
      chk("bclk_oe", 2'h1, {1'b0, bclk.oe});
      @(posedge bclk.o);
      #1;
      chk("lead_before", 2'h0, {1'b0, ccl});
      @(posedge mclk);
      #1;
      chk("lead_after", 2'h1, {1'b0, ccl});
      // one core clock is four mclk, so eight samples see four level changes
      prev = bclk.o;
      repeat (8)
      begin
         @(posedge mclk);
         #1;
         if (bclk.o !== prev)
            edges++;
         prev = bclk.o;
         chk("bclk_inv", {1'b1, ~bclk.o}, {bclkn.oe, bclkn.o});
      end
      chk("bclk_active", 2'h1, {1'b0, edges == 4});
      cfg.address_tracing_enable = 1'b0;
      tk(2);
      repeat (8)
      begin
         @(posedge mclk);
         #1;
         chk("bclk_still", 2'h0, {1'b0, bclk.o});
      end
   endtask

   task automatic s_release();
      grant_on = 1'b0;
      tk(2);
      chk("busy_high", 2'h3, busy);
      tk(1);
      chk("busy_float", 2'h0, {1'b0, busy.oe});
      chk("line_pulled", 2'h1, {1'b0, busy_in});
      chk("slave", 2'h0, {1'b0, st.is_master});
      chk("bclkn_float", 2'h0, {1'b0, bclkn.oe});
      chk("bclk_float", 2'h0, {1'b0, bclk.oe});
      chk("cas_float", 2'h0, {1'b0, cas.oe});
      // slave with mastership enable set holds the strobe inactive high
      cfg.mastership_enable_bit = 1'b1;
      tk(1);
      chk("cas_parked", 2'h3, cas);
      cfg.mastership_enable_bit = 1'b0;
   endtask

   // reset in mid-run while owning and holding the lock, then win the bus again
   task automatic s_reset_mid();
      s_acquire();
      cfg.lock_hold_bit = 1'b1;
      tk(2);
      chk("hold_before_rst", 2'h0, {1'b0, lock_n});
      nrst = 1'b0;
      @(posedge mclk);
      #1;
      chk("rst_mid_busy", 2'h0, {1'b0, busy.oe});
      chk("rst_mid_lock", 2'h1, {1'b0, lock_n});
      chk("rst_mid_master", 2'h0, {1'b0, st.is_master});
      cfg.lock_hold_bit = 1'b0;
      @(posedge mclk);
      #1;
      nrst = 1'b1;
      tk(3);
      chk("rst_mid_reown", 2'h1, {1'b0, st.is_master});
   endtask

   // watchdog well beyond the few hundred cycles the run needs
   initial
   begin
      #20000;
      mismatches++;
      stop_test();
   end

   initial
   begin
      req.cas_n = 1'b1;
      // reset falls after time zero so the asynchronous resets see an edge
      #1;
      nrst = 1'b0;
      repeat (8) @(posedge mclk);
      #1;
      chk("rst_busy", 2'h0, {1'b0, busy.oe});
      chk("rst_lock", 2'h1, {1'b0, lock_n});
      chk("rst_req", 2'h1, {1'b0, req_n});
      nrst = 1'b1;
      s_acquire();
      for (int i = 0; i < 4; i++)
         s_rmw(ext_bus_pkg::instr_op_t'(i), 1'b1);
      s_rmw(ext_bus_pkg::OP_BIT_SET_INSTR, 1'b0);
      s_hold_park();
      s_clk();
      s_release();
      s_reset_mid();
      stop_test();
   end
endmodule // ext_bus_mastership_lock_bench

`default_nettype wire
